// >>> rtl/dcff_regs.svh
// constants for the status-flag fifo core
`ifndef DCFF_REGS_SVH
`define DCFF_REGS_SVH
// array depth and word width
`define DCFF_DEPTH 1024
`define DCFF_WIDTH 36
// offset register width
`define DCFF_OFF_W 10
// default offsets, index {load_select_n, sel1, sel0}
`define DCFF_OFF_000 10'h07f
`define DCFF_OFF_001 10'h0ff
`define DCFF_OFF_010 10'h1ff
`define DCFF_OFF_011 10'h03f
`define DCFF_OFF_100 10'h01f
`define DCFF_OFF_101 10'h007
`define DCFF_OFF_110 10'h00f
`define DCFF_OFF_111 10'h003
// wait edges before the first word loads the output
`define DCFF_WARM_LAST 2'h2
`endif

// >>> rtl/dcff_pkg.sv
// types shared by the status-flag fifo core
`include "dcff_regs.svh"
package dcff_pkg;
    // strap choices caught at master reset
    typedef struct packed {
        logic first_word_fall_through;
        logic serial;
        logic [`DCFF_OFF_W-1:0] empty_off;
        logic [`DCFF_OFF_W-1:0] full_off;
    } dcff_mode_type;
    // shared level flags, all active low
    typedef struct packed {
        logic empty_n;
        logic full_n;
        logic almost_empty_n;
        logic almost_full_n;
        logic half_full_n;
    } dcff_flags_type;
endpackage

// >>> rtl/dcff_core.sv
// fifo core with standard and fall-through status flags
// Functional notes
// - strap low: standard mode, empty/full flags
// - strap high: fall-through, ready flags
// - first word appears after three edges
// - output-ready low after first write
// - fall-through almost-empty high at n+2
// - fall-through half-full low at 514th
// - fall-through almost-full low at 1025-m
// - input-ready high at depth plus one
// - read from full clears input-ready
// - fall-through almost-empty low at n+1
// - output-ready high after last read
// - read enable ignored while empty
// - output-ready three stages, input-ready two
// - standard empty flag high after write
// - standard almost-empty high at n+1
// - standard half-full low at 513rd
// - standard almost-full low at 1024-m
// - full low at depth, read clears
// - almost-empty low at n, empty after last
// - default offsets chosen by straps
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dcff_regs.svh"

module dcff_core
    import dcff_pkg::*;
#(
    parameter int DEPTH = `DCFF_DEPTH,
    parameter int WIDTH = `DCFF_WIDTH
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_write_enable_n,
    input wire logic [WIDTH-1:0] i_write_data,
    input wire logic i_read_enable_n,
    input wire logic i_fallthrough_select_serial_in,
    input wire logic i_load_select_n,
    input wire logic i_offset_select_0,
    input wire logic i_offset_select_1,
    output logic [WIDTH-1:0] o_read_data_out,
    output logic o_empty_flag_n,
    output logic o_full_flag_n,
    output logic o_output_ready_n,
    output logic o_input_ready_n,
    output logic o_almost_empty_n,
    output logic o_almost_full_n,
    output logic o_half_full_n,
    output logic o_first_word_fall_through,
    output logic o_serial_load_mode
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 2);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_C = CW'(DEPTH / 2);

    // default offset decode
    function automatic logic [`DCFF_OFF_W-1:0] dcff_def_off(input logic [2:0] sel);
        case (sel)
            3'h0: dcff_def_off = `DCFF_OFF_000;
            3'h1: dcff_def_off = `DCFF_OFF_001;
            3'h2: dcff_def_off = `DCFF_OFF_010;
            3'h3: dcff_def_off = `DCFF_OFF_011;
            3'h4: dcff_def_off = `DCFF_OFF_100;
            3'h5: dcff_def_off = `DCFF_OFF_101;
            3'h6: dcff_def_off = `DCFF_OFF_110;
            default: dcff_def_off = `DCFF_OFF_111;
        endcase
    endfunction

    // flag levels from a word count; fall-through adds the output word
    function automatic dcff_flags_type dcff_flag_calc(
        input logic [CW-1:0] cnt,
        input dcff_mode_type md
    );
        logic [CW-1:0] ex;
        ex = CW'(md.first_word_fall_through);
        dcff_flag_calc.empty_n = (cnt != '0);
        dcff_flag_calc.full_n = (cnt != DEPTH_C + ex);
        dcff_flag_calc.almost_empty_n = (cnt > CW'(md.empty_off) + ex);
        dcff_flag_calc.half_full_n = !(cnt > HALF_C + ex);
        dcff_flag_calc.almost_full_n = !(cnt >= DEPTH_C + ex - CW'(md.full_off));
    endfunction

    // strap synchroniser stages
    logic [3:0] strap_m_q;
    logic [3:0] strap_s_q;
    // captured mode and offsets
    dcff_mode_type mode_q;
    dcff_mode_type mode_d;
    // storage array
    logic [WIDTH-1:0] mem_q [DEPTH];
    // pointers
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] wptr_d;
    logic [AW-1:0] rptr_q;
    logic [AW-1:0] rptr_d;
    // total words held, output word included
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    // words held in the array only
    logic [CW-1:0] mem_cnt;
    // output register holds a word
    logic ov_q;
    logic ov_d;
    // first-word wait counter
    logic [1:0] warm_q;
    logic [1:0] warm_d;
    // output data
    logic [WIDTH-1:0] data_q;
    logic [WIDTH-1:0] data_d;
    // accepted accesses
    logic wr_acc;
    logic rd_std;
    logic rd_fw;
    logic pop;
    // flag registers
    dcff_flags_type flg_q;
    dcff_flags_type flg_d;
    logic or_n_q;
    logic or_n_d;
    logic ir1_q;
    logic ir1_d;
    logic ir_q;

    // two flops on the strap pins
    always_ff @(posedge i_core_clk) begin
        strap_m_q <= {i_fallthrough_select_serial_in, i_load_select_n,
                      i_offset_select_1, i_offset_select_0};
        strap_s_q <= strap_m_q;
    end

    // straps are caught while master reset is held
    always_comb begin
        mode_d = mode_q;
        if (!i_rst_n) begin
            mode_d.first_word_fall_through = strap_s_q[3];
            mode_d.serial = strap_s_q[2];
            mode_d.empty_off = dcff_def_off(strap_s_q[2:0]);
            mode_d.full_off = dcff_def_off(strap_s_q[2:0]);
        end
    end

    // mode register
    always_ff @(posedge i_core_clk) begin
        mode_q <= mode_d;
    end

    // access decode and next state
    always_comb begin
        mem_cnt = cnt_q - CW'(ov_q);
        wr_acc = !i_write_enable_n && (mem_cnt != DEPTH_C);
        rd_std = !mode_q.first_word_fall_through && !i_read_enable_n && (cnt_q != '0);
        // reads in fall-through need a shown word
        rd_fw = mode_q.first_word_fall_through && !i_read_enable_n && ov_q;
        pop = rd_std;
        warm_d = '0;
        ov_d = ov_q;
        if (mode_q.first_word_fall_through && mem_cnt != '0) begin
            if (ov_q) begin
                // refill on read
                pop = rd_fw;
            end else begin
                pop = (warm_q == `DCFF_WARM_LAST);
                warm_d = pop ? 2'h0 : warm_q + 2'h1;
            end
        end
        if (mode_q.first_word_fall_through) begin
            if (pop) begin
                ov_d = 1'b1;
            end else if (rd_fw) begin
                ov_d = 1'b0;
            end
        end
        wptr_d = wr_acc ? wptr_q + AW'(1) : wptr_q;
        rptr_d = pop ? rptr_q + AW'(1) : rptr_q;
        data_d = pop ? mem_q[rptr_q] : data_q;
        cnt_d = cnt_q + CW'(wr_acc) - CW'(rd_std || rd_fw);
        flg_d = dcff_flag_calc(cnt_d, mode_q);
        flg_d.empty_n = flg_d.empty_n && !mode_q.first_word_fall_through;
        flg_d.full_n = flg_d.full_n || mode_q.first_word_fall_through;
        or_n_d = !(mode_q.first_word_fall_through && ov_d);
        // input-ready up at depth plus one
        ir1_d = mode_q.first_word_fall_through && (cnt_d == DEPTH_C + CW'(1));
    end

    // array writes, no reset on storage
    always_ff @(posedge i_core_clk) begin
        if (wr_acc) begin
            mem_q[wptr_q] <= i_write_data;
        end
    end

    // pointer, count and flag registers
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q <= '0;
            ov_q <= 1'b0;
            warm_q <= '0;
            data_q <= '0;
            flg_q <= '{empty_n: 1'b0, full_n: 1'b1, almost_empty_n: 1'b0,
                       almost_full_n: 1'b1, half_full_n: 1'b1};
            or_n_q <= 1'b1;
            ir1_q <= 1'b0;
            ir_q <= 1'b0;
        end else begin
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            cnt_q <= cnt_d;
            ov_q <= ov_d;
            warm_q <= warm_d;
            data_q <= data_d;
            flg_q <= flg_d;
            or_n_q <= or_n_d;
            ir1_q <= ir1_d;
            ir_q <= ir1_q;
        end
    end

    // outputs straight from flops
    assign o_read_data_out = data_q;
    assign o_empty_flag_n = flg_q.empty_n;
    assign o_full_flag_n = flg_q.full_n;
    assign o_almost_empty_n = flg_q.almost_empty_n;
    assign o_almost_full_n = flg_q.almost_full_n;
    assign o_half_full_n = flg_q.half_full_n;
    assign o_output_ready_n = or_n_q;
    assign o_input_ready_n = ir_q;
    assign o_first_word_fall_through = mode_q.first_word_fall_through;
    assign o_serial_load_mode = mode_q.serial;

    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    // first write into an empty fall-through fifo
    sequence s_fw_first;
        mode_q.first_word_fall_through && cnt_q == '0 && wr_acc;
    endsequence
    // output hidden through the third edge, shown right after it
    sequence s_fw_show;
        ##3 o_output_ready_n ##1 !o_output_ready_n;
    endsequence
    property p_fw_first;
        s_fw_first |-> s_fw_show;
    endproperty
    a_fw_first: assert property (p_fw_first)
        else $error("first word not shown after three edges");

    property p_std_empty;
        !mode_q.first_word_fall_through && cnt_q == '0 && wr_acc |=> o_empty_flag_n;
    endproperty
    a_std_empty: assert property (p_std_empty)
        else $error("empty flag did not rise on first write");

    property p_no_read_empty;
        cnt_q == '0 |=> $stable(o_read_data_out) && $stable(rptr_q);
    endproperty
    a_no_read_empty: assert property (p_no_read_empty)
        else $error("read moved while empty");

    property p_no_overwrite;
        mem_cnt == DEPTH_C |=> $stable(wptr_q);
    endproperty
    a_no_overwrite: assert property (p_no_overwrite)
        else $error("write pointer moved while full");

    property p_std_full;
        !mode_q.first_word_fall_through && cnt_q == DEPTH_C |-> !o_full_flag_n;
    endproperty
    a_std_full: assert property (p_std_full)
        else $error("full flag not low at depth");

    property p_fw_ir;
        mode_q.first_word_fall_through && cnt_q == DEPTH_C + CW'(1) |=> o_input_ready_n;
    endproperty
    a_fw_ir: assert property (p_fw_ir)
        else $error("input-ready not high when full");

    property p_half;
        cnt_q > HALF_C + CW'(mode_q.first_word_fall_through) |-> !o_half_full_n;
    endproperty
    a_half: assert property (p_half)
        else $error("half-full not low past half");

    property p_fw_ae;
        mode_q.first_word_fall_through && cnt_q <= CW'(mode_q.empty_off) + CW'(1) |-> !o_almost_empty_n;
    endproperty
    a_fw_ae: assert property (p_fw_ae)
        else $error("almost-empty high at or below n+1");

    property p_std_drained;
        !mode_q.first_word_fall_through && cnt_q == '0 |-> !o_empty_flag_n;
    endproperty
    a_std_drained: assert property (p_std_drained)
        else $error("empty flag high with no words");

    property p_or_high;
        mode_q.first_word_fall_through && cnt_q == '0 |-> o_output_ready_n;
    endproperty
    a_or_high: assert property (p_or_high)
        else $error("output-ready low while empty");

    property p_count;
        (rd_std || rd_fw) && wr_acc |=> $stable(cnt_q);
    endproperty
    a_count: assert property (p_count)
        else $error("count moved on read plus write");

    property p_mode_hold;
        i_rst_n |=> $stable(mode_q);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("mode changed outside reset");

endmodule // dcff_core
`default_nettype wire

// >>> dv/dcff_agent.sv
// writer and reader agent driving the fifo core ports
`timescale 1ns/1ps
`default_nettype none
module dcff_agent
    import dcff_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_wr_req, // write one word next cycle
    input wire logic i_rd_req, // read one word next cycle
    output logic o_write_enable_n,
    output logic [35:0] o_write_data,
    output logic o_read_enable_n
);
    logic [31:0] seq_q; // number of the next word
    // one request per asked cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            seq_q <= 32'h1;
            o_write_enable_n <= 1'b1;
            o_read_enable_n <= 1'b1;
            o_write_data <= 36'h0;
        end else begin
            o_write_enable_n <= !i_wr_req;
            o_read_enable_n <= !i_rd_req;
            if (i_wr_req) begin
                o_write_data <= {4'h5, seq_q};
                seq_q <= seq_q + 32'h1;
            end else begin
                // idle data toggles so no stale word passes
                o_write_data <= ~o_write_data;
            end
        end
    end
endmodule // dcff_agent
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the status-flag fifo core
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dcff_pkg::*;
    localparam int D = 16; // shrunk depth
    int n_off; // offset picked by the straps of the last reset
    logic clk, rst_n, wr_req, rd_req, fw_sel, wen_n, ren_n;
    logic ld_sel, sel1, sel0; // offset straps
    logic ef, ff, orf, irf, ae, af, hf, fw_q, ser;
    logic [35:0] wdata, rdata, last;
    logic [6:0] fl;
    logic [35:0] q[$]; // words held, oldest first
    int n_errors, n_checks, cnt, seq;
    int cyc = 0;
    bit fwm;
    assign fl = {ef, ff, ae, af, hf, orf, irf};
    dcff_agent i_dcff_agent (.i_core_clk(clk), .i_rst_n(rst_n), .i_wr_req(wr_req),
        .i_rd_req(rd_req), .o_write_enable_n(wen_n), .o_write_data(wdata),
        .o_read_enable_n(ren_n));
    dcff_core #(.DEPTH(D)) i_dcff_core (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_write_enable_n(wen_n), .i_write_data(wdata), .i_read_enable_n(ren_n),
        .i_fallthrough_select_serial_in(fw_sel), .i_load_select_n(ld_sel),
        .i_offset_select_0(sel0), .i_offset_select_1(sel1), .o_read_data_out(rdata),
        .o_empty_flag_n(ef), .o_full_flag_n(ff), .o_output_ready_n(orf),
        .o_input_ready_n(irf), .o_almost_empty_n(ae), .o_almost_full_n(af),
        .o_half_full_n(hf), .o_first_word_fall_through(fw_q), .o_serial_load_mode(ser));
    // expected flags for a word count
    function automatic logic [6:0] exp_fl(int c, bit fw);
        if (fw)
            return {1'b0, 1'b1, c >= n_off + 2, c < D + 1 - n_off, c < D / 2 + 2, c == 0, c > D};
        return {c > 0, c < D, c >= n_off + 1, c < D - n_off, c < D / 2 + 1, 1'b1, 1'b0};
    endfunction
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one request through the agent, model updated
    task automatic req(input bit w, input bit r);
        bit wok;
        // a write against a full fifo is refused even beside a read
        wok = w && cnt < (fwm ? D + 1 : D);
        wr_req <= w;
        rd_req <= r;
        @(posedge clk);
        wr_req <= 1'b0;
        rd_req <= 1'b0;
        if (r && cnt > 0) begin
            last = q.pop_front();
            cnt--;
        end
        if (w)
            seq++;
        if (wok) begin
            q.push_back({4'h5, 32'(seq)});
            cnt++;
        end
    endtask
    // request, settle, judge flags and data
    task automatic step(input bit w, input bit r);
        req(w, r);
        repeat (5) @(posedge clk);
        #1;
        chk(fl, exp_fl(cnt, fwm));
        if (r && !fwm)
            chk(rdata, last);
        if (fwm && cnt > 0)
            chk(rdata, q[0]);
    endtask
    // master reset with mode and offset straps, n the offset they select
    task automatic do_reset(input bit fw, input bit ld, input bit s1, input bit s0, input int n);
        @(posedge clk);
        fw_sel <= fw;
        ld_sel <= ld;
        sel1 <= s1;
        sel0 <= s0;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        fwm = fw;
        n_off = n;
        cnt = 0;
        seq = 0;
        q.delete();
        @(posedge clk);
        #1;
        // thresholds only exist for offsets inside the shrunk depth
        if (n < D)
            chk(fl, exp_fl(0, fw));
        chk(fw_q, fw);
        chk(ser, ld);
        chk(rdata, 36'h0);
    endtask
    // standard mode: fill past full, drain past empty
    task automatic t_std();
        do_reset(1'b0, 1'b1, 1'b1, 1'b1, 3);
        for (int i = 0; i <= D; i++)
            step(1'b1, 1'b0);
        // read beside a refused write at full
        step(1'b1, 1'b1);
        for (int i = 0; i < D / 2; i++)
            step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b1);
        while (cnt > 0)
            step(1'b0, 1'b1);
        step(1'b0, 1'b1);
    endtask
    // fall-through mode: first word latency, fill, drain
    task automatic t_first_word_fall_through();
        do_reset(1'b1, 1'b1, 1'b0, 1'b1, 7);
        req(1'b1, 1'b0);
        repeat (3) @(posedge clk);
        #1;
        chk(orf, 1'b1);
        @(posedge clk);
        #1;
        chk(orf, 1'b0);
        chk(rdata, q[0]);
        for (int i = 0; i <= D; i++)
            step(1'b1, 1'b0);
        // read beside a refused write at full, then both taken
        step(1'b1, 1'b1);
        step(1'b1, 1'b1);
        while (cnt > 0)
            step(1'b0, 1'b1);
        step(1'b0, 1'b1);
    endtask
    // parallel load strap back in standard mode
    task automatic t_par();
        do_reset(1'b0, 1'b0, 1'b0, 1'b1, 255);
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        rst_n = 1'b0;
        fw_sel = 1'b0;
        ld_sel = 1'b1;
        sel1 = 1'b1;
        sel0 = 1'b1;
        wr_req = 1'b0;
        rd_req = 1'b0;
        n_errors = 0;
        n_checks = 0;
        t_std();
        t_first_word_fall_through();
        t_par();
        end_of_test();
    end
endmodule // tb
`default_nettype wire
